// File: logic/pokef_defs.svh
// Register indexes, field positions and reset values of the status bank
`ifndef POKEF_DEFS_SVH
`define POKEF_DEFS_SVH

// ************************************************************
// Register indexes (byte address is four times the index)
// ************************************************************
`define POKEF_IDX_PG_LO      8'h37
`define POKEF_IDX_PG_HI      8'h38
`define POKEF_IDX_FLAGS      8'h39
`define POKEF_IDX_MASK       8'h3a
`define POKEF_IDX_CLEAR      8'h40
`define POKEF_IDX_MONITOR_THRESHOLD_SELECT   8'h41

// ************************************************************
// Word address field and transfer type
// ************************************************************
`define POKEF_ADDR_LSB       2
`define POKEF_ADDR_MSB       9
`define POKEF_HTRANS_ACTIVE  1

// ************************************************************
// Event flag bit positions
// ************************************************************
`define POKEF_BIT_PIN1_FALL  7
`define POKEF_BIT_PIN1_RISE  6
`define POKEF_BIT_THERMAL    5
`define POKEF_BIT_HOLD_RISE  4
`define POKEF_BIT_LONG_PRESS 3
`define POKEF_BIT_BUTTON     2
`define POKEF_BIT_DROP       1
`define POKEF_BIT_HOLD_FALL  0

// ************************************************************
// Reset values
// ************************************************************
`define POKEF_RST_PG         8'h00
`define POKEF_RST_FLAGS      8'h00
`define POKEF_RST_MASK       8'hff
`define POKEF_RST_MONITOR_THRESHOLD_SELECT   2'h0
`define POKEF_PG_HI_RSVD     2'h0

`endif

// File: logic/pokef_pkg.sv
// Types shared by the power-good and event flag bank
package pokef_pkg;

   typedef logic [7:0] pokef_byte_t;
   typedef logic [1:0] pokef_vsel_t;

   typedef enum logic [1:0]
   {
      PH_IDLE,
      PH_WRITE,
      PH_READ
   } pokef_phase_t;

endpackage

// File: logic/pokef_edge.sv
// Edge detector for a group of synchronous event inputs
`timescale 1ns/1ps
`default_nettype none

module pokef_edge
#(
   parameter int WIDTH = 5
)
(
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic [WIDTH-1:0] level_in,
   output logic      [WIDTH-1:0] rise_out,
   output logic      [WIDTH-1:0] fall_out
);

   logic [WIDTH-1:0] prev;
   logic             primed;

   // ************************************************************
   // History of the inputs
   // ************************************************************
   // Primed blocks a false edge from the reset value of the history
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         prev   <= '0;
         primed <= 1'b0;
      end
      else
      begin
         prev   <= level_in;
         primed <= 1'b1;
      end
   end

   assign rise_out = primed ? (level_in & ~prev) : '0;
   assign fall_out = primed ? (~level_in & prev) : '0;

endmodule

`default_nettype wire

// File: logic/pokef_top.sv
// Power-good status and event flag register bank with AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "pokef_defs.svh"

module pokef_top
(
   input  wire logic                  sys_clk_in,
   input  wire logic                  arst_n_in,
   input  wire logic                  hsel_in,
   input  wire logic [31:0]           haddr_in,
   input  wire logic [1:0]            htrans_in,
   input  wire logic                  hwrite_in,
   input  wire logic [2:0]            hsize_in,
   input  wire logic [31:0]           hwdata_in,
   input  wire logic                  hready_in,
   input  wire logic                  buck1_power_ok_in,
   input  wire logic                  buck2_power_ok_in,
   input  wire logic                  linreg5_power_ok_in,
   input  wire logic                  linreg6_power_ok_in,
   input  wire logic                  linreg7_power_ok_in,
   input  wire logic                  linreg8_power_ok_in,
   input  wire logic                  linreg9_power_ok_in,
   input  wire logic                  linreg10_power_ok_in,
   input  wire logic                  gpio_pin1_in,
   input  wire logic                  thermal_warn_in,
   input  wire logic                  power_hold_input_in,
   input  wire logic                  power_button_n_in,
   input  wire logic                  long_press_in,
   input  wire logic [3:0]            supply_below_in,
   output logic      [31:0]           hrdata_out,
   output logic                       hreadyout_out,
   output logic                       hresp_out,
   output logic                       irq_out,
   output pokef_pkg::pokef_vsel_t     monitor_threshold_select_out
);

   import pokef_pkg::*;

   logic          rst_meta;
   logic          rst_n;
   pokef_phase_t  phase;
   logic [7:0]    addr_q;
   pokef_byte_t   pg_lo;
   pokef_byte_t   pg_hi;
   pokef_byte_t   event_flags;
   pokef_byte_t   event_mask_reg;
   pokef_vsel_t   monitor_threshold_select;
   logic          drop_prev;
   logic [4:0]    edge_rise;
   logic [4:0]    edge_fall;
   logic          drop_level;
   logic          accept;
   logic          wr_en;
   pokef_byte_t   wr_byte;
   pokef_byte_t   ev;
   pokef_byte_t   clr;
   pokef_byte_t   next_flags;

   // ************************************************************
   // Reset release
   // ************************************************************
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ************************************************************
   // Register read decode
   // ************************************************************
   function automatic pokef_byte_t read_reg(input logic [7:0] idx);
      pokef_byte_t val;
      val = 8'h00;
      unique case (idx)
         `POKEF_IDX_PG_LO:    val = pg_lo;
         `POKEF_IDX_PG_HI:    val = pg_hi;
         `POKEF_IDX_FLAGS:    val = event_flags;
         `POKEF_IDX_MASK:     val = event_mask_reg;
         `POKEF_IDX_MONITOR_THRESHOLD_SELECT: val = {6'h00, monitor_threshold_select};
         default:             val = 8'h00;
      endcase
      return val;
   endfunction

   // ************************************************************
   // AHB-Lite slave
   // ************************************************************
   assign accept  = hsel_in && hready_in && htrans_in[`POKEF_HTRANS_ACTIVE];
   assign wr_en   = (phase == PH_WRITE);
   assign wr_byte = hwdata_in[7:0];

   // Reads take one wait state so read data come out of a register
   always_ff @(posedge sys_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase         <= PH_IDLE;
         addr_q        <= 8'h00;
         hrdata_out    <= 32'h0000_0000;
         hreadyout_out <= 1'b1;
         hresp_out     <= 1'b0;
      end
      else
      begin
         unique case (phase)
            PH_READ:
            begin
               hrdata_out    <= {24'h000000, read_reg(addr_q)};
               hreadyout_out <= 1'b1;
               phase         <= PH_IDLE;
            end
            PH_IDLE,
            PH_WRITE:
            begin
               if (accept)
               begin
                  addr_q <= haddr_in[`POKEF_ADDR_MSB:`POKEF_ADDR_LSB];
                  phase  <= hwrite_in ? PH_WRITE : PH_READ;
                  hreadyout_out <= hwrite_in;
               end
               else
               begin
                  phase <= PH_IDLE;
               end
            end
         endcase
      end
   end

   // ************************************************************
   // Power-good capture
   // ************************************************************
   always_ff @(posedge sys_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pg_lo <= `POKEF_RST_PG;
         pg_hi <= `POKEF_RST_PG;
      end
      else
      begin
         // Comparator levels copied every cycle; bus writes never reach them
         pg_lo <= {6'h00, buck2_power_ok_in,
                   buck1_power_ok_in};
         pg_hi <= {`POKEF_PG_HI_RSVD, linreg10_power_ok_in,
                   linreg9_power_ok_in, linreg8_power_ok_in,
                   linreg7_power_ok_in, linreg6_power_ok_in,
                   linreg5_power_ok_in};
      end
   end

   // ************************************************************
   // Control registers
   // ************************************************************
   always_ff @(posedge sys_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         event_mask_reg           <= `POKEF_RST_MASK;
         monitor_threshold_select <= `POKEF_RST_MONITOR_THRESHOLD_SELECT;
      end
      else if (wr_en)
      begin
         if (addr_q == `POKEF_IDX_MASK)
            event_mask_reg <= wr_byte;
         if (addr_q == `POKEF_IDX_MONITOR_THRESHOLD_SELECT)
            monitor_threshold_select <= wr_byte[1:0];
      end
   end

   assign monitor_threshold_select_out = monitor_threshold_select;

   // ************************************************************
   // Event detection
   // ************************************************************
   pokef_edge
   #(
      .WIDTH    (5)
   )
   u_edge
   (
      .clk_in   (sys_clk_in),
      .rst_n_in (rst_n),
      .level_in ({gpio_pin1_in, thermal_warn_in, power_hold_input_in,
                  power_button_n_in, long_press_in}),
      .rise_out (edge_rise),
      .fall_out (edge_fall)
   );

   // Selected threshold comparator; no filtering before the flag
   assign drop_level = supply_below_in[monitor_threshold_select];

   always_ff @(posedge sys_clk_in or negedge rst_n)
   begin
      if (!rst_n)
         drop_prev <= 1'b1;
      else
         drop_prev <= drop_level;
   end

   always_comb
   begin
      ev = 8'h00;
      ev[`POKEF_BIT_PIN1_FALL]  = edge_fall[4];
      ev[`POKEF_BIT_PIN1_RISE]  = edge_rise[4];
      ev[`POKEF_BIT_THERMAL]    = edge_rise[3];
      ev[`POKEF_BIT_HOLD_RISE]  = edge_rise[2];
      ev[`POKEF_BIT_HOLD_FALL]  = edge_fall[2];
      ev[`POKEF_BIT_BUTTON]     = edge_fall[1];
      ev[`POKEF_BIT_LONG_PRESS] = edge_rise[0];
      ev[`POKEF_BIT_DROP]       = drop_level & ~drop_prev;
   end

   // ************************************************************
   // Event flags and interrupt
   // ************************************************************
   assign clr = (wr_en && (addr_q == `POKEF_IDX_FLAGS ||
                           addr_q == `POKEF_IDX_CLEAR)) ? wr_byte : 8'h00;
   assign next_flags = (event_flags & ~clr) | ev;

   always_ff @(posedge sys_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         event_flags <= `POKEF_RST_FLAGS;
         irq_out     <= 1'b0;
      end
      else
      begin
         event_flags <= next_flags;
         irq_out     <= |(next_flags & ~event_mask_reg);
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n);

   a_pg_lo_follow: assert property (
      ##1 pg_lo == {6'h00, $past(buck2_power_ok_in),
                    $past(buck1_power_ok_in)})
      else $error("low power-good register does not follow inputs");
   a_pg_hi_rsvd: assert property (
      (pg_hi[7:6] == 2'h0) and
      (##1 pg_hi[5] == $past(linreg10_power_ok_in)))
      else $error("high power-good layout wrong");
   a_flags_cleared: assert property (
      $rose(rst_n) |-> event_flags == 8'h00)
      else $error("flags not clear after reset");
   a_flag_sticky: assert property (
      (event_flags[5] && !(clr[5])) |=> event_flags[5])
      else $error("flag dropped without a clear");
   a_set_beats_clear: assert property (
      ((ev & clr) != 8'h00) |=>
      ((event_flags & $past(ev & clr)) == $past(ev & clr)))
      else $error("event lost under clear");
   a_pin1_edges: assert property (
      ($fell(gpio_pin1_in) && $past(rst_n)) |=> event_flags[7])
      else $error("pin one fall not flagged");
   a_hold_edges: assert property (
      ($rose(power_hold_input_in) && $past(rst_n)) |=> event_flags[4])
      else $error("hold rise not flagged");
   a_button_press: assert property (
      ($fell(power_button_n_in) && $past(rst_n)) |=> event_flags[2])
      else $error("button press not flagged");
   a_drop_flag: assert property (
      ev[1] |=> event_flags[1])
      else $error("supply drop not flagged");
   a_irq_mask: assert property (
      ##1 irq_out == |(event_flags & ~$past(event_mask_reg)))
      else $error("interrupt does not match flags and mask");
   a_read_wait: assert property (
      (accept && !hwrite_in) |=> !hreadyout_out ##1 hreadyout_out)
      else $error("read wait state wrong");

   c_read_flags: cover property (
      accept && !hwrite_in &&
      haddr_in[`POKEF_ADDR_MSB:`POKEF_ADDR_LSB] == `POKEF_IDX_FLAGS);
   c_clear_flag: cover property (event_flags[7] ##1 !event_flags[7]);
   c_irq_raise: cover property (!irq_out ##1 irq_out);
   c_collision: cover property ((ev & clr) != 8'h00);

endmodule

`default_nettype wire

// File: test/tb_power_ok_and_event_flags.sv
// Self-checking bench for the power-good and event flag bank
`timescale 1ns/1ps
`default_nettype none
`include "pokef_defs.svh"

module tb_power_ok_and_event_flags;
   import pokef_pkg::*;

   typedef struct packed
   {
      logic [8:0] ev;
      logic [7:0] pg;
      logic [7:0] exp;
   } pokef_row_t;

   // ***********************************************************
   // Signals; ev is {pin1, thermal, hold, button_n, long, below}
   // ***********************************************************
   logic        sys_clk;
   logic        arst_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic        irq;
   pokef_vsel_t vsel;
   logic [7:0]  pg;
   logic [8:0]  ev;
   logic [31:0] rd;
   int          err_count;
   int          comparisons;
   int          cycles;

   pokef_row_t rows [12] = '{
      '{9'h120, 8'h01, 8'h40}, '{9'h020, 8'h02, 8'h80},
      '{9'h0a0, 8'h04, 8'h20}, '{9'h020, 8'h08, 8'h00},
      '{9'h060, 8'h10, 8'h10}, '{9'h020, 8'h20, 8'h01},
      '{9'h000, 8'h40, 8'h04}, '{9'h020, 8'h80, 8'h00},
      '{9'h030, 8'hff, 8'h08}, '{9'h020, 8'haa, 8'h00},
      '{9'h021, 8'h55, 8'h02}, '{9'h020, 8'h00, 8'h00}};

   pokef_top u_pokef_top
   (
      .sys_clk_in                   (sys_clk),
      .arst_n_in                    (arst_n),
      .hsel_in                      (hsel),
      .haddr_in                     (haddr),
      .htrans_in                    (htrans),
      .hwrite_in                    (hwrite),
      .hsize_in                     (3'h2),
      .hwdata_in                    (hwdata),
      .hready_in                    (hready),
      .buck1_power_ok_in            (pg[0]),
      .buck2_power_ok_in            (pg[1]),
      .linreg5_power_ok_in          (pg[2]),
      .linreg6_power_ok_in          (pg[3]),
      .linreg7_power_ok_in          (pg[4]),
      .linreg8_power_ok_in          (pg[5]),
      .linreg9_power_ok_in          (pg[6]),
      .linreg10_power_ok_in         (pg[7]),
      .gpio_pin1_in                 (ev[8]),
      .thermal_warn_in              (ev[7]),
      .power_hold_input_in          (ev[6]),
      .power_button_n_in            (ev[5]),
      .long_press_in                (ev[4]),
      .supply_below_in              (ev[3:0]),
      .hrdata_out                   (hrdata),
      .hreadyout_out                (hready),
      .hresp_out                    (hresp),
      .irq_out                      (irq),
      .monitor_threshold_select_out (vsel)
   );

   always #50 sys_clk = ~sys_clk;

   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         err_count++;
         conclude();
      end
   end

   // ***********************************************************
   // Bus cycles, comparisons and closing report
   // ***********************************************************
   task automatic addr_phase(input logic [7:0] idx, input logic wr);
      haddr <= {22'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge sys_clk); while (hready !== 1'b1);
      htrans <= 2'b00;
   endtask

   task automatic rd_reg(input logic [7:0] idx, output logic [31:0] d);
      addr_phase(idx, 1'b0);
      do @(posedge sys_clk); while (hready !== 1'b1);
      d = hrdata;
   endtask

   // Tog flips pin one in the data phase, against the clearing write
   task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d,
                         input logic tog);
      addr_phase(idx, 1'b1);
      hwdata <= {24'h0, d};
      if (tog)
         ev[8] <= ~ev[8];
      do @(posedge sys_clk); while (hready !== 1'b1);
   endtask

   task automatic chk_reg(input logic [7:0] idx, input logic [31:0] exp);
      rd_reg(idx, rd);
      comparisons++;
      if (rd !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, rd, exp);
      end
   endtask

   task automatic chk_pin(input logic got, input logic exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic settle();
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic do_reset();
      arst_n <= 1'b0;
      settle();
      arst_n <= 1'b1;
      settle();
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      sys_clk = 1'b0;
      arst_n = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      pg = 8'h00;
      ev = 9'h020;
      err_count = 0;
      comparisons = 0;
      cycles = 0;
      @(posedge sys_clk);
      do_reset();
      chk_reg(`POKEF_IDX_FLAGS, 32'h0);
      chk_reg(`POKEF_IDX_MASK, 32'hff);
      chk_pin(irq, 1'b0);
      chk_pin(hresp, 1'b0);
      foreach (rows[i])
      begin
         ev <= rows[i].ev;
         pg <= rows[i].pg;
         settle();
         chk_reg(`POKEF_IDX_FLAGS,
                 {24'h0, rows[i].exp});
         chk_reg(`POKEF_IDX_PG_LO, {30'h0, rows[i].pg[1:0]});
         chk_reg(`POKEF_IDX_PG_HI, {26'h0, rows[i].pg[7:2]});
         chk_pin(irq, 1'b0);
         wr_reg(`POKEF_IDX_FLAGS, 8'hff, 1'b0);
      end
      ev <= 9'h160;
      settle();
      wr_reg(`POKEF_IDX_FLAGS, 8'h00, 1'b0);
      chk_reg(`POKEF_IDX_FLAGS, 32'h50);
      wr_reg(`POKEF_IDX_FLAGS, 8'h10, 1'b0);
      chk_reg(`POKEF_IDX_FLAGS, 32'h40);
      wr_reg(`POKEF_IDX_MASK, 8'hbf, 1'b0);
      settle();
      chk_pin(irq, 1'b1);
      wr_reg(8'h40, 8'h40, 1'b0);
      settle();
      chk_pin(irq, 1'b0);
      chk_reg(8'h40, 32'h0);
      ev <= 9'h020;
      settle();
      wr_reg(`POKEF_IDX_FLAGS, 8'hff, 1'b0);
      wr_reg(`POKEF_IDX_FLAGS, 8'h40, 1'b1);
      chk_reg(`POKEF_IDX_FLAGS, 32'h40);
      chk_pin(irq, 1'b1);
      ev <= 9'h020;
      wr_reg(`POKEF_IDX_MASK, 8'hff, 1'b0);
      wr_reg(`POKEF_IDX_FLAGS, 8'hff, 1'b0);
      for (int k = 0; k < 4; k++)
      begin
         wr_reg(`POKEF_IDX_MONITOR_THRESHOLD_SELECT, k[7:0], 1'b0);
         chk_reg(`POKEF_IDX_MONITOR_THRESHOLD_SELECT, k);
         chk_pin(vsel[1], k[1]);
         chk_pin(vsel[0], k[0]);
         ev <= 9'h020 | (9'h1 << ((k + 1) % 4));
         settle();
         chk_reg(`POKEF_IDX_FLAGS, 32'h0);
         ev <= ev | (9'h1 << k);
         settle();
         chk_reg(`POKEF_IDX_FLAGS, 32'h02);
         ev <= 9'h020;
         wr_reg(`POKEF_IDX_FLAGS, 8'hff, 1'b0);
      end
      wr_reg(`POKEF_IDX_PG_HI, 8'hff, 1'b0);
      chk_reg(`POKEF_IDX_PG_HI, 32'h0);
      wr_reg(8'h10, 8'hff, 1'b0);
      chk_reg(8'h10, 32'h0);
      ev <= 9'h120;
      wr_reg(`POKEF_IDX_MASK, 8'h00, 1'b0);
      settle();
      chk_pin(irq, 1'b1);
      do_reset();
      chk_pin(irq, 1'b0);
      chk_reg(`POKEF_IDX_FLAGS, 32'h0);
      chk_reg(`POKEF_IDX_MASK, 32'hff);
      conclude();
   end

endmodule
`default_nettype wire
